// [verilog/uart_shadow_map.svh]
`ifndef UART_SHADOW_MAP_SVH
`define UART_SHADOW_MAP_SVH

// Byte addresses of the aliased shadow window and the control words.
`define SHADOW_FIRST    32'h5000_1130
`define SHADOW_14       32'h5000_1168
`define SHADOW_15       32'h5000_116C
`define CTRL_ADDR       32'h5000_1190
`define STATUS_ADDR     32'h5000_1194

// Field positions.
`define CTRL_FIFO_EN    0
`define CTRL_IR_MODE    1
`define ST_DATA_READY   0
`define ST_OVERRUN      1
`define ST_THR_EMPTY    5

// Sizes and reset values.
`define FIFO_DEPTH      16
`define BYTE_MSB        7
`define RESET_WORD      32'h0000_0000

`endif

// [verilog/uart_shadow_pkg.sv]
package uart_shadow_pkg;

  // One character on the line.
  typedef logic [7:0]  char_t;

  // One APB data word.
  typedef logic [31:0] word_t;

endpackage

// [verilog/shadow_skid_buffer.sv]
`include "uart_shadow_map.svh"

// Two-entry buffer between the transmit queue and the serialiser.
module shadow_skid_buffer
  import uart_shadow_pkg::*;
(
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  in_valid,
  output logic       in_ready,
  input  wire char_t in_data,
  output logic       out_valid,
  input  wire logic  out_ready,
  output char_t      out_data
);

  logic  head_v_r, head_v_nxt;
  logic  spare_v_r, spare_v_nxt;
  char_t head_r, head_nxt;
  char_t spare_r, spare_nxt;
  logic  in_fire, out_fire;

  assign out_valid = head_v_r;
  assign out_data  = head_r;

  // A second slot lets the receiver stall without losing the word in flight.
  always_comb begin
    in_fire     = in_valid & in_ready;
    out_fire    = head_v_r & out_ready;
    head_v_nxt  = head_v_r;
    spare_v_nxt = spare_v_r;
    head_nxt    = head_r;
    spare_nxt   = spare_r;
    if (out_fire) begin
      if (spare_v_r) begin
        head_nxt    = spare_r;
        spare_v_nxt = 1'b0;
      end else begin
        head_nxt   = in_data;
        head_v_nxt = in_fire;
      end
    end else if (in_fire) begin
      if (!head_v_r) begin
        head_nxt   = in_data;
        head_v_nxt = 1'b1;
      end else begin
        spare_nxt   = in_data;
        spare_v_nxt = 1'b1;
      end
    end
  end

  // Ready is registered so the filling side never sees a combinational path.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head_v_r  <= 1'b0;
      spare_v_r <= 1'b0;
      head_r    <= '0;
      spare_r   <= '0;
      in_ready  <= 1'b0;
    end else begin
      head_v_r  <= head_v_nxt;
      spare_v_r <= spare_v_nxt;
      head_r    <= head_nxt;
      spare_r   <= spare_nxt;
      in_ready  <= ~spare_v_nxt;
    end
  end

endmodule

// [verilog/uart_shadow_buffer_port.sv]
// Behaviour
// R1 - Sixteen word addresses all alias the one receive and transmit data path.
// R2 - A shadow read returns the byte from the serial or infrared input in bits 7:0.
// R3 - Returned data is valid only while the data-ready flag is set.
// R4 - With FIFOs off a new byte overwrites an unread one and flags overrun.
// R5 - With FIFOs on a shadow read returns and pops the receive FIFO head.
// R6 - A byte arriving at a full receive FIFO is dropped and flags overrun.
// R7 - A written byte is queued for the serial or the infrared output.
// R8 - The master writes only while the holding-empty flag is set.
// R9 - With FIFOs off one write clears the holding-empty flag.
// R10 - With FIFOs off further writes overwrite the pending byte.
// R11 - With FIFOs on writes are accepted up to the FIFO depth.
// R12 - A write to a full transmit FIFO is discarded.
// R13 - Bits 15:8 of a shadow location read zero and ignore writes.
// R14 - Only a real read pops, and a read with no data changes nothing.
`include "uart_shadow_map.svh"

module uart_shadow_buffer_port
  import uart_shadow_pkg::*;
#(
  parameter int DEPTH = `FIFO_DEPTH
)(
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  psel,
  input  wire logic  penable,
  input  wire logic  pwrite,
  input  wire word_t paddr,
  input  wire word_t pwdata,
  output word_t      prdata,
  output logic       pready,
  output logic       pslverr,
  input  wire logic  rx_valid_uart,
  input  wire char_t rx_byte_uart,
  input  wire logic  rx_valid_ir,
  input  wire char_t rx_byte_ir,
  output logic       tx_valid,
  input  wire logic  tx_ready,
  output char_t      tx_byte,
  output logic       tx_ir_mode
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic          access, done, shadow_hit, ctrl_hit, status_hit, any_hit;
  logic          rd_shadow, wr_shadow, wr_ctrl, rd_status;
  word_t         rdata;
  word_t         prdata_nxt;
  logic          pready_nxt, pslverr_nxt;
  logic          fifo_en_r, fifo_en_nxt, ir_mode_r, ir_mode_nxt, flush;
  logic          overrun_r, overrun_nxt, ovr_set;
  logic [CW-1:0] rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
  logic [AW-1:0] rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt;
  logic [AW-1:0] tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
  logic [AW-1:0] rx_wa, tx_wa;
  logic          rx_we, tx_we, rx_push, rx_pop, tx_pop, buf_ready;
  char_t         rx_in;
  char_t         rx_mem [DEPTH];
  char_t         tx_mem [DEPTH];

  // The shadow window is a range of word-aligned addresses decoded by comparison; every word in it is the same port.
  always_comb begin
    access     = psel & penable;
    done       = access & pready;
    shadow_hit = (paddr >= `SHADOW_FIRST) && (paddr <= `SHADOW_15) &&
                 (paddr[1:0] == 2'b00); // R1
    ctrl_hit   = (paddr == `CTRL_ADDR);
    status_hit = (paddr == `STATUS_ADDR);
    any_hit    = shadow_hit | ctrl_hit | status_hit;
    rd_shadow  = done & shadow_hit & ~pwrite; // R14
    wr_shadow  = done & shadow_hit & pwrite;
    wr_ctrl    = done & ctrl_hit & pwrite;
    rd_status  = done & status_hit & ~pwrite;
  end

  // Read data mux; bits above the character are held at zero.
  always_comb begin
    rdata = `RESET_WORD;
    if (shadow_hit && rx_cnt_r != '0) begin
      rdata[`BYTE_MSB:0] = rx_mem[rx_rp_r]; // R2 R3 R13
    end else if (ctrl_hit) begin
      rdata[`CTRL_FIFO_EN] = fifo_en_r;
      rdata[`CTRL_IR_MODE] = ir_mode_r;
    end else if (status_hit) begin
      rdata[`ST_DATA_READY] = (rx_cnt_r != '0); // R3
      rdata[`ST_OVERRUN]    = overrun_r;
      rdata[`ST_THR_EMPTY]  = (tx_cnt_r == '0);
    end
  end

  // One wait state: data and ready leave flops, at the cost of a cycle.
  always_comb begin
    pready_nxt  = access & ~pready;
    prdata_nxt  = (pready_nxt & ~pwrite) ? rdata : `RESET_WORD;
    pslverr_nxt = pready_nxt & ~any_hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= `RESET_WORD;
      pslverr <= 1'b0;
    end else begin
      pready  <= pready_nxt;
      prdata  <= prdata_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits.

  // Changing the FIFO mode empties both queues; the two skid buffer entries are not flushed.
  always_comb begin
    fifo_en_nxt = fifo_en_r;
    ir_mode_nxt = ir_mode_r;
    flush       = 1'b0;
    if (wr_ctrl) begin
      fifo_en_nxt = pwdata[`CTRL_FIFO_EN];
      ir_mode_nxt = pwdata[`CTRL_IR_MODE];
      flush       = pwdata[`CTRL_FIFO_EN] != fifo_en_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_en_r  <= 1'b0;
      ir_mode_r  <= 1'b0;
      tx_ir_mode <= 1'b0;
    end else begin
      fifo_en_r  <= fifo_en_nxt;
      ir_mode_r  <= ir_mode_nxt;
      tx_ir_mode <= ir_mode_nxt; // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive queue.

  // With FIFOs off only entry zero is used, so a second byte lands on the first.
  always_comb begin
    rx_push     = ir_mode_r ? rx_valid_ir : rx_valid_uart; // R2
    rx_in       = ir_mode_r ? rx_byte_ir : rx_byte_uart;
    rx_pop      = rd_shadow & (rx_cnt_r != '0); // R14
    rx_cnt_nxt  = rx_cnt_r;
    rx_wp_nxt   = rx_wp_r;
    rx_rp_nxt   = rx_rp_r;
    rx_we       = 1'b0;
    rx_wa       = rx_wp_r;
    ovr_set     = 1'b0;
    if (rx_pop) begin
      rx_rp_nxt  = (fifo_en_r && rx_rp_r != LAST) ? rx_rp_r + 1'b1 : '0; // R5
      rx_cnt_nxt = rx_cnt_r - 1'b1;
    end
    if (rx_push) begin
      if (!fifo_en_r) begin
        rx_we      = 1'b1;
        rx_wa      = '0;
        rx_rp_nxt  = '0;
        rx_cnt_nxt = CW'(1);
        ovr_set    = (rx_cnt_r != '0) & ~rx_pop; // R4
      end else if (rx_cnt_r == FULL && !rx_pop) begin
        ovr_set = 1'b1; // R6
      end else begin
        rx_we      = 1'b1;
        rx_wp_nxt  = (rx_wp_r != LAST) ? rx_wp_r + 1'b1 : '0;
        rx_cnt_nxt = rx_pop ? rx_cnt_r : rx_cnt_r + 1'b1;
      end
    end
    if (flush) begin
      rx_cnt_nxt = '0;
      rx_wp_nxt  = '0;
      rx_rp_nxt  = '0;
    end
    // A new overrun in the cycle of a status read still stands afterwards.
    overrun_nxt = ovr_set | (overrun_r & ~rd_status);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt_r  <= '0;
      rx_wp_r   <= '0;
      rx_rp_r   <= '0;
      overrun_r <= 1'b0;
    end else begin
      rx_cnt_r  <= rx_cnt_nxt;
      rx_wp_r   <= rx_wp_nxt;
      rx_rp_r   <= rx_rp_nxt;
      overrun_r <= overrun_nxt;
    end
  end

  // Storage is not reset; the counts guard every read of it.
  always_ff @(posedge pclk) begin
    if (rx_we) begin
      rx_mem[rx_wa] <= rx_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit queue.

  // Only bits 7:0 of the written word are taken.
  always_comb begin
    tx_pop     = (tx_cnt_r != '0) & buf_ready;
    tx_cnt_nxt = tx_cnt_r;
    tx_wp_nxt  = tx_wp_r;
    tx_rp_nxt  = tx_rp_r;
    tx_we      = 1'b0;
    tx_wa      = tx_wp_r;
    if (tx_pop) begin
      tx_rp_nxt  = (fifo_en_r && tx_rp_r != LAST) ? tx_rp_r + 1'b1 : '0;
      tx_cnt_nxt = tx_cnt_r - 1'b1;
    end
    if (wr_shadow) begin
      if (!fifo_en_r) begin
        tx_we      = 1'b1; // R9 R10
        tx_wa      = '0;
        tx_rp_nxt  = '0;
        tx_cnt_nxt = CW'(1);
      end else if (tx_cnt_r != FULL || tx_pop) begin
        tx_we      = 1'b1; // R11
        tx_wp_nxt  = (tx_wp_r != LAST) ? tx_wp_r + 1'b1 : '0;
        tx_cnt_nxt = tx_pop ? tx_cnt_r : tx_cnt_r + 1'b1;
      end
    end
    if (flush) begin
      tx_cnt_nxt = '0;
      tx_wp_nxt  = '0;
      tx_rp_nxt  = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt_r <= '0;
      tx_wp_r  <= '0;
      tx_rp_r  <= '0;
    end else begin
      tx_cnt_r <= tx_cnt_nxt;
      tx_wp_r  <= tx_wp_nxt;
      tx_rp_r  <= tx_rp_nxt;
    end
  end

  // A full queue takes no write unless it pops in the same cycle, so the held bytes stay as they were.
  always_ff @(posedge pclk) begin
    if (tx_we) begin
      tx_mem[tx_wa] <= pwdata[`BYTE_MSB:0]; // R7 R12 R13
    end
  end

  // The serialiser stalls through tx_ready; the queue waits on the buffer.
  shadow_skid_buffer u_skid (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (tx_pop),
    .in_ready  (buf_ready),
    .in_data   (tx_mem[tx_rp_r]),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_bus_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pready |=> pready ##1 !pready)
    else $error("ready did not follow one wait state");
  a_rd_pop_one: assert property (@(posedge pclk) disable iff (!presetn) // R5
    rd_shadow && rx_cnt_r != '0 && fifo_en_r && !rx_push && !flush
    |=> rx_cnt_r == $past(rx_cnt_r) - 1'b1)
    else $error("read did not pop one entry");
  a_rd_empty_keep: assert property (@(posedge pclk) disable iff (!presetn) // R14
    rd_shadow && rx_cnt_r == '0 && !rx_push |=> rx_cnt_r == '0 && $stable(rx_rp_r))
    else $error("empty read changed the receive state");
  a_rd_data_head: assert property (@(posedge pclk) disable iff (!presetn) // R2
    pready_nxt && !pwrite && shadow_hit && rx_cnt_r != '0
    |=> prdata[`BYTE_MSB:0] == $past(rx_mem[rx_rp_r]))
    else $error("shadow read returned the wrong byte");
  a_rd_high_zero: assert property (@(posedge pclk) disable iff (!presetn) // R13
    pready && shadow_hit |-> prdata[31:8] == '0)
    else $error("reserved read bits not zero");
  a_ovr_direct: assert property (@(posedge pclk) disable iff (!presetn) // R4
    !fifo_en_r && rx_push && rx_cnt_r != '0 && !rx_pop && !flush
    |=> overrun_r && rx_cnt_r == CW'(1) && rx_mem[0] == $past(rx_in))
    else $error("direct overwrite not flagged");
  a_ovr_full_keep: assert property (@(posedge pclk) disable iff (!presetn) // R6
    fifo_en_r && rx_push && rx_cnt_r == FULL && !rx_pop && !flush
    |=> overrun_r && rx_cnt_r == FULL && $stable(rx_wp_r))
    else $error("full receive queue not preserved");
  a_thr_clear: assert property (@(posedge pclk) disable iff (!presetn) // R9
    !fifo_en_r && wr_shadow && tx_cnt_r == '0 && !flush
    |=> tx_cnt_r == CW'(1) ##1 tx_cnt_r <= CW'(1))
    else $error("write did not clear holding empty");
  a_tx_accept: assert property (@(posedge pclk) disable iff (!presetn) // R11
    fifo_en_r && wr_shadow && tx_cnt_r != FULL && !tx_pop && !flush
    |=> tx_cnt_r == $past(tx_cnt_r) + 1'b1)
    else $error("transmit write not accepted");
  a_tx_full_drop: assert property (@(posedge pclk) disable iff (!presetn) // R12
    fifo_en_r && wr_shadow && tx_cnt_r == FULL && !tx_pop && !flush
    |=> tx_cnt_r == FULL && $stable(tx_wp_r))
    else $error("write to full queue was taken");

  // The status word must mirror the queues as they stood when it was captured.
  a_stat_ready: assert property (@(posedge pclk) disable iff (!presetn) // R3
    pready_nxt && !pwrite && status_hit
    |=> prdata[`ST_DATA_READY] == ($past(rx_cnt_r) != '0))
    else $error("data-ready flag does not match the receive count");
  a_stat_empty: assert property (@(posedge pclk) disable iff (!presetn) // R9
    pready_nxt && !pwrite && status_hit
    |=> prdata[`ST_THR_EMPTY] == ($past(tx_cnt_r) == '0))
    else $error("holding-empty flag does not match the transmit count");
  a_stat_ovr: assert property (@(posedge pclk) disable iff (!presetn) // R4
    pready_nxt && !pwrite && status_hit |=> prdata[`ST_OVERRUN] == $past(overrun_r))
    else $error("overrun flag not reported");
  a_empty_read_zero: assert property (@(posedge pclk) disable iff (!presetn) // R14
    pready_nxt && !pwrite && shadow_hit && rx_cnt_r == '0 |=> prdata == `RESET_WORD)
    else $error("read with no data returned a stale byte");

  // A bad address must be answered with an error, a good one never.
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn) // R1
    pready_nxt && !any_hit |=> pslverr && prdata == `RESET_WORD)
    else $error("unmapped address not refused");
  a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn) // R1
    pready_nxt && any_hit |=> !pslverr)
    else $error("mapped address refused");

  // Overrun is sticky until software reads the status word.
  a_ovr_clear: assert property (@(posedge pclk) disable iff (!presetn) // R4
    rd_status && !ovr_set |=> !overrun_r)
    else $error("status read did not clear overrun");
  a_ovr_sticky: assert property (@(posedge pclk) disable iff (!presetn) // R6
    overrun_r && !rd_status |=> overrun_r)
    else $error("overrun cleared without a status read");
  a_rx_full_no_write: assert property (@(posedge pclk) disable iff (!presetn) // R6
    fifo_en_r && rx_push && rx_cnt_r == FULL && !rx_pop |-> !rx_we)
    else $error("full receive queue was written");
  a_rx_cnt_bound: assert property (@(posedge pclk) disable iff (!presetn) // R6
    rx_cnt_r <= FULL)
    else $error("receive count beyond depth");

  // Transmit side: overwrite without FIFOs, bounded queue with them.
  a_tx_overwrite: assert property (@(posedge pclk) disable iff (!presetn) // R10
    !fifo_en_r && wr_shadow && !flush
    |=> tx_cnt_r == CW'(1) && tx_mem[0] == $past(pwdata[`BYTE_MSB:0]))
    else $error("pending byte not overwritten");
  a_tx_cnt_bound: assert property (@(posedge pclk) disable iff (!presetn) // R11
    tx_cnt_r <= FULL)
    else $error("transmit count beyond depth");
  a_tx_mode_follow: assert property (@(posedge pclk) disable iff (!presetn) // R7
    wr_ctrl |=> tx_ir_mode == $past(pwdata[`CTRL_IR_MODE]))
    else $error("output select did not follow the mode bit");

endmodule

// [testbench/serial_peer_model.sv]
// Far side of the block: the serialisers and receivers of the line.
module serial_peer_model
  import uart_shadow_pkg::*;
(
  input  wire logic  pclk,
  input  wire logic  stall,
  input  wire logic  tx_valid,
  input  wire char_t tx_byte,
  input  wire logic  tx_ir_mode,
  output logic       tx_ready,
  output logic       rx_valid_uart,
  output char_t      rx_byte_uart,
  output logic       rx_valid_ir,
  output char_t      rx_byte_ir
);
  logic [8:0] got[$];

  ////////////////////////////////////////////////////////////////////////////////
  // The receivers start idle; their byte lines carry no meaning yet.
  initial begin
    rx_valid_uart = 1'b0;
    rx_valid_ir   = 1'b0;
    rx_byte_uart  = 8'h00;
    rx_byte_ir    = 8'h00;
  end

  // The serialiser may hold off, so that the buffers in front of it fill up.
  assign tx_ready = !stall;

  // Each byte taken is logged with the output that it was meant for.
  always @(posedge pclk) begin
    if (tx_valid && tx_ready) begin
      got.push_back({tx_ir_mode, tx_byte});
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One received byte as a one-cycle pulse; afterwards the line shows the
  // inverse, so that a design sampling stale data cannot pass by luck.
  task automatic send(input logic ir, input char_t b);
    @(posedge pclk);
    if (ir) begin
      rx_valid_ir <= 1'b1;
      rx_byte_ir  <= b;
    end else begin
      rx_valid_uart <= 1'b1;
      rx_byte_uart  <= b;
    end
    @(posedge pclk);
    rx_valid_ir   <= 1'b0;
    rx_valid_uart <= 1'b0;
    if (ir) rx_byte_ir <= ~b;
    else rx_byte_uart <= ~b;
  endtask
endmodule

// [testbench/tb_uart_shadow_buffer_port.sv]
`include "uart_shadow_map.svh"

module tb_uart_shadow_buffer_port
  import uart_shadow_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic  pclk, presetn, psel, penable, pwrite, pready, pslverr, stall;
  word_t paddr, pwdata, prdata;
  logic  rx_valid_uart, rx_valid_ir, tx_valid, tx_ready, tx_ir_mode;
  char_t rx_byte_uart, rx_byte_ir, tx_byte;
  int    n_fail;
  int    samples_checked;

  uart_shadow_buffer_port #(.DEPTH(`FIFO_DEPTH)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid_uart(rx_valid_uart),
    .rx_byte_uart(rx_byte_uart), .rx_valid_ir(rx_valid_ir),
    .rx_byte_ir(rx_byte_ir), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_byte(tx_byte), .tx_ir_mode(tx_ir_mode));

  serial_peer_model u_peer (
    .pclk(pclk), .stall(stall), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ir_mode(tx_ir_mode), .tx_ready(tx_ready), .rx_valid_uart(rx_valid_uart),
    .rx_byte_uart(rx_byte_uart), .rx_valid_ir(rx_valid_ir), .rx_byte_ir(rx_byte_ir));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 100 MHz.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Comparison of any returned word against its expectation.
  task automatic chk(input word_t got, input word_t exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen at a rising edge,
  // and the answer is taken at that same edge before anything is released.
  task automatic apb(input logic wr, input word_t a, input word_t wd,
                     output word_t rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t no pready from the slave", $time);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input word_t a, input word_t d);
    word_t r;
    logic  e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input word_t a, input word_t exp);
    word_t r;
    logic  e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
  endtask

  // Waits, bounded, until the serialiser has taken the given count of bytes.
  task automatic wait_tx(input int cnt);
    for (int i = 0; i < 300 && u_peer.got.size() < cnt; i++) @(posedge pclk);
    repeat (20) @(posedge pclk);
    chk(word_t'(u_peer.got.size()), word_t'(cnt));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and an unmapped address.
  task automatic t_reset;
    word_t r;
    logic  e;
    rd(`SHADOW_14, 32'h0000_0000);
    rd(`SHADOW_15, 32'h0000_0000);
    rd(`STATUS_ADDR, 32'h0000_0020);
    apb(1'b0, 32'h5000_1180, 32'h0000_0000, r, e);
    chk({31'h0, e}, 32'h0000_0001);
    chk(r, 32'h0000_0000);
  endtask

  // Without FIFOs a second byte overwrites the unread one.
  task automatic t_rx_off;
    u_peer.send(1'b0, 8'hA5);
    u_peer.send(1'b0, 8'h3C);
    rd(`STATUS_ADDR, 32'h0000_0023);
    rd(`STATUS_ADDR, 32'h0000_0021);
    rd(`SHADOW_14, 32'h0000_003C);
    rd(`SHADOW_14, 32'h0000_0000);
    u_peer.send(1'b1, 8'h77);
    rd(`STATUS_ADDR, 32'h0000_0020);
  endtask

  // With FIFOs a full receive queue drops the extra byte; reads walk the aliases.
  task automatic t_rx_fifo;
    wr(`CTRL_ADDR, 32'h0000_0001);
    for (int i = 0; i <= `FIFO_DEPTH; i++) u_peer.send(1'b0, char_t'(8'h10 + i));
    rd(`STATUS_ADDR, 32'h0000_0023);
    for (int i = 0; i < `FIFO_DEPTH; i++) rd(`SHADOW_FIRST + 4 * i, 32'h10 + i);
    rd(`STATUS_ADDR, 32'h0000_0020);
  endtask

  // Infrared mode takes the infrared byte and sends on the infrared output.
  task automatic t_ir;
    wr(`CTRL_ADDR, 32'h0000_0003);
    u_peer.send(1'b1, 8'hC3);
    u_peer.send(1'b0, 8'h55);
    rd(`SHADOW_15, 32'h0000_00C3);
    rd(`STATUS_ADDR, 32'h0000_0020);
    u_peer.got.delete();
    wr(`SHADOW_15, 32'hFFFF_AB96);
    wait_tx(1);
    chk(word_t'(u_peer.got[0]), 32'h0000_0196);
  endtask

  // A stalled serialiser fills the two-entry skid buffer and the transmit FIFO; writes beyond both are lost.
  task automatic t_tx_fifo;
    wr(`CTRL_ADDR, 32'h0000_0001);
    u_peer.got.delete();
    stall <= 1'b1;
    for (int i = 0; i < `FIFO_DEPTH + 4; i++) wr(`SHADOW_FIRST + 4 * (i % 16), 32'h40 + i);
    rd(`STATUS_ADDR, 32'h0000_0000);
    stall <= 1'b0;
    wait_tx(`FIFO_DEPTH + 2);
    for (int i = 0; i < `FIFO_DEPTH + 2; i++) chk(word_t'(u_peer.got[i]), 32'h40 + i);
  endtask

  // Without FIFOs a second pending write replaces the first.
  task automatic t_tx_off;
    wr(`CTRL_ADDR, 32'h0000_0000);
    u_peer.got.delete();
    stall <= 1'b1;
    rd(`STATUS_ADDR, 32'h0000_0020);
    wr(`SHADOW_14, 32'h0000_00A1);
    wr(`SHADOW_14, 32'h0000_00B2);
    wr(`SHADOW_14, 32'h0000_00C3);
    rd(`STATUS_ADDR, 32'h0000_0000);
    wr(`SHADOW_15, 32'h0000_00D4);
    stall <= 1'b0;
    wait_tx(3);
    chk(word_t'(u_peer.got[2]), 32'h0000_00D4);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict in one place, reached by the sequence or by the watchdog.
  task automatic end_of_test;
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // A hang costs far more than the whole sequence should ever take.
  initial begin
    #200us;
    n_fail++;
    end_of_test();
  end

  // Main sequence after four cycles of reset.
  initial begin
    n_fail = 0;
    samples_checked = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, stall} = 4'h0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rx_off();
    t_rx_fifo();
    t_ir();
    t_tx_fifo();
    t_tx_off();
    end_of_test();
  end
endmodule
